//--- logic/agot_regs.v
// Gain and offset trim register bank for converters 15 and 16, with the
// per-sample correction that the coefficients steer.
// Assumes one clock, a one-cycle strobe bus master, and samples at 14-bit scale.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "agot_defs.vh"

////////////////////////////////////////////////////////////////////////////////

module agot_regs #(
  parameter SMP_W = `AGOT_SMP_W
) (
  input  wire                     clk_i,
  input  wire                     nrst_i,
  input  wire [`AGOT_ADDR_W-1:0]  addr_i,
  input  wire [`AGOT_DATA_W-1:0]  wdata_i,
  input  wire                     wr_i,
  input  wire                     rd_i,
  output reg  [`AGOT_DATA_W-1:0]  rdata_o,
  input  wire                     global_gain_correction_enable_i,
  input  wire                     global_offset_correction_enable_i,
  input  wire                     c15_valid_i,
  input  wire                     c15_odd_i,
  input  wire [SMP_W-1:0]         c15_sample_i,
  input  wire                     c16_valid_i,
  input  wire                     c16_odd_i,
  input  wire [SMP_W-1:0]         c16_sample_i,
  output wire                     c15_valid_o,
  output wire [SMP_W-1:0]         c15_sample_o,
  output wire [`AGOT_GAIN_W-1:0]  c15_gain_o,
  output wire [`AGOT_GAIN_W+4:0]  c15_gain_cdb_o,
  output wire                     c16_valid_o,
  output wire [SMP_W-1:0]         c16_sample_o,
  output wire [`AGOT_GAIN_W-1:0]  c16_gain_o,
  output wire [`AGOT_GAIN_W+4:0]  c16_gain_cdb_o
);

  wire [`AGOT_DATA_W-1:0] c15_odd_r;
  wire [`AGOT_DATA_W-1:0] c15_even_r;
  wire [`AGOT_DATA_W-1:0] c16_odd_r;
  wire [`AGOT_DATA_W-1:0] c16_even_r;
  wire                    c15_odd_we;
  wire                    c15_even_we;
  wire                    c16_odd_we;
  wire                    c16_even_we;
  reg  [`AGOT_DATA_W-1:0] rdata_nxt;

  //////////////////////////////////////////////////////////////////////////////

  // Exact decode: writes to any other address are dropped.
  assign c15_odd_we  = wr_i && (addr_i == `AGOT_OFF_C15_ODD);
  assign c15_even_we = wr_i && (addr_i == `AGOT_OFF_C15_EVEN);
  assign c16_odd_we  = wr_i && (addr_i == `AGOT_OFF_C16_ODD);
  assign c16_even_we = wr_i && (addr_i == `AGOT_OFF_C16_EVEN);

  agot_coef_reg #(
    .DATA_W  (`AGOT_DATA_W),
    .RST_VAL (`AGOT_REG_RST)
  ) u_agot_coef_reg_c15_odd (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .we_i    (c15_odd_we),
    .wdata_i (wdata_i),
    .q_o     (c15_odd_r)
  );

  agot_coef_reg #(
    .DATA_W  (`AGOT_DATA_W),
    .RST_VAL (`AGOT_REG_RST)
  ) u_agot_coef_reg_c15_even (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .we_i    (c15_even_we),
    .wdata_i (wdata_i),
    .q_o     (c15_even_r)
  );

  agot_coef_reg #(
    .DATA_W  (`AGOT_DATA_W),
    .RST_VAL (`AGOT_REG_RST)
  ) u_agot_coef_reg_c16_odd (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .we_i    (c16_odd_we),
    .wdata_i (wdata_i),
    .q_o     (c16_odd_r)
  );

  agot_coef_reg #(
    .DATA_W  (`AGOT_DATA_W),
    .RST_VAL (`AGOT_REG_RST)
  ) u_agot_coef_reg_c16_even (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .we_i    (c16_even_we),
    .wdata_i (wdata_i),
    .q_o     (c16_even_r)
  );

  // Unmapped addresses read zero; data stands only in the cycle after the strobe.
  always @* begin
    rdata_nxt = `AGOT_RD_IDLE;
    if (rd_i) begin
      case (addr_i)
        `AGOT_OFF_C15_ODD:  rdata_nxt = c15_odd_r;
        `AGOT_OFF_C15_EVEN: rdata_nxt = c15_even_r;
        `AGOT_OFF_C16_ODD:  rdata_nxt = c16_odd_r;
        `AGOT_OFF_C16_EVEN: rdata_nxt = c16_even_r;
        default:            rdata_nxt = `AGOT_RD_IDLE;
      endcase
    end
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= `AGOT_RD_IDLE;
    end else begin
      rdata_o <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  agot_trim_chan #(
    .SMP_W  (SMP_W),
    .DATA_W (`AGOT_DATA_W),
    .GAIN_W (`AGOT_GAIN_W),
    .OFFS_W (`AGOT_OFFS_W)
  ) u_agot_trim_chan_c15 (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .odd_coef_i  (c15_odd_r),
    .even_coef_i (c15_even_r),
    .gain_en_i   (global_gain_correction_enable_i),
    .offs_en_i   (global_offset_correction_enable_i),
    .valid_i     (c15_valid_i),
    .odd_i       (c15_odd_i),
    .sample_i    (c15_sample_i),
    .valid_o     (c15_valid_o),
    .sample_o    (c15_sample_o),
    .gain_o      (c15_gain_o),
    .gain_cdb_o  (c15_gain_cdb_o)
  );

  agot_trim_chan #(
    .SMP_W  (SMP_W),
    .DATA_W (`AGOT_DATA_W),
    .GAIN_W (`AGOT_GAIN_W),
    .OFFS_W (`AGOT_OFFS_W)
  ) u_agot_trim_chan_c16 (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .odd_coef_i  (c16_odd_r),
    .even_coef_i (c16_even_r),
    .gain_en_i   (global_gain_correction_enable_i),
    .offs_en_i   (global_offset_correction_enable_i),
    .valid_i     (c16_valid_i),
    .odd_i       (c16_odd_i),
    .sample_i    (c16_sample_i),
    .valid_o     (c16_valid_o),
    .sample_o    (c16_sample_o),
    .gain_o      (c16_gain_o),
    .gain_cdb_o  (c16_gain_cdb_o)
  );

endmodule

////////////////////////////////////////////////////////////////////////////////

// One coefficient word; the spare bit is kept as written so every bit reads back.
module agot_coef_reg #(
  parameter DATA_W  = `AGOT_DATA_W,
  parameter RST_VAL = `AGOT_REG_RST
) (
  input  wire              clk_i,
  input  wire              nrst_i,
  input  wire              we_i,
  input  wire [DATA_W-1:0] wdata_i,
  output reg  [DATA_W-1:0] q_o
);

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_o <= RST_VAL[DATA_W-1:0];
    end else if (we_i) begin
      q_o <= wdata_i;
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////////

// Picks the coefficient word that matches the parity of the sample in flight.
module agot_parity_sel #(
  parameter DATA_W = `AGOT_DATA_W
) (
  input  wire              odd_i,
  input  wire [DATA_W-1:0] odd_coef_i,
  input  wire [DATA_W-1:0] even_coef_i,
  output reg  [DATA_W-1:0] coef_o
);

  always @* begin
    coef_o = odd_i ? odd_coef_i : even_coef_i;
  end

endmodule

////////////////////////////////////////////////////////////////////////////////

// Clamps a difference that is one bit wider back to the sample width.
module agot_sat #(
  parameter SMP_W = `AGOT_SMP_W
) (
  input  wire [SMP_W:0]   val_i,
  output reg  [SMP_W-1:0] val_o
);

  always @* begin
    if (val_i[SMP_W] != val_i[SMP_W-1]) begin
      val_o = {val_i[SMP_W], {(SMP_W-1){~val_i[SMP_W]}}};
    end else begin
      val_o = val_i[SMP_W-1:0];
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////////

// One converter's trim path: parity picks the coefficient word, the gain field
// is exposed as a code and in centi-dB, and the offset is subtracted with a
// clamp so that a large trim never wraps a full-scale sample to the other rail.
module agot_trim_chan #(
  parameter SMP_W  = `AGOT_SMP_W,
  parameter DATA_W = `AGOT_DATA_W,
  parameter GAIN_W = `AGOT_GAIN_W,
  parameter OFFS_W = `AGOT_OFFS_W
) (
  input  wire              clk_i,
  input  wire              nrst_i,
  input  wire [DATA_W-1:0] odd_coef_i,
  input  wire [DATA_W-1:0] even_coef_i,
  input  wire              gain_en_i,
  input  wire              offs_en_i,
  input  wire              valid_i,
  input  wire              odd_i,
  input  wire [SMP_W-1:0]  sample_i,
  output reg               valid_o,
  output reg  [SMP_W-1:0]  sample_o,
  output reg  [GAIN_W-1:0] gain_o,
  output reg  [GAIN_W+4:0] gain_cdb_o
);

  localparam CDB_W = GAIN_W + 5;
  localparam PAD_W = CDB_W - GAIN_W;
  localparam EXT_W = SMP_W + 1 - OFFS_W;

  wire [DATA_W-1:0] coef_sel;
  wire [GAIN_W-1:0] gain_field;
  wire [OFFS_W-1:0] offs_field;
  wire [GAIN_W-1:0] gain_nxt;
  wire [CDB_W-1:0]  gain_cdb_nxt;
  wire [SMP_W:0]    offs_ext;
  wire [SMP_W:0]    smp_ext;
  wire [SMP_W:0]    diff;
  wire [SMP_W-1:0]  diff_sat;
  wire [SMP_W-1:0]  sample_nxt;

  //////////////////////////////////////////////////////////////////////////////

  agot_parity_sel #(
    .DATA_W (DATA_W)
  ) u_agot_parity_sel (
    .odd_i       (odd_i),
    .odd_coef_i  (odd_coef_i),
    .even_coef_i (even_coef_i),
    .coef_o      (coef_sel)
  );

  assign gain_field = coef_sel[`AGOT_GAIN_MSB:`AGOT_GAIN_LSB];
  assign offs_field = coef_sel[`AGOT_OFFS_MSB:`AGOT_OFFS_LSB];

  assign gain_nxt = gain_en_i ? gain_field : {GAIN_W{1'b0}};

  // Both factors are widened so the product is exactly as wide as the output.
  assign gain_cdb_nxt = {{PAD_W{1'b0}}, gain_nxt} * {{PAD_W{1'b0}}, `AGOT_GAIN_STEP_CDB};

  // Sign-extend the offset; one unit is one LSB of the 14-bit sample.
  assign offs_ext = {{EXT_W{offs_field[OFFS_W-1]}}, offs_field};
  assign smp_ext  = {sample_i[SMP_W-1], sample_i};
  assign diff     = smp_ext - offs_ext;

  agot_sat #(
    .SMP_W (SMP_W)
  ) u_agot_sat (
    .val_i (diff),
    .val_o (diff_sat)
  );

  assign sample_nxt = offs_en_i ? diff_sat : sample_i;

  //////////////////////////////////////////////////////////////////////////////

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      valid_o <= 1'b0;
    end else begin
      valid_o <= valid_i;
    end
  end

  // The last corrected sample holds between valid strobes.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sample_o <= {SMP_W{1'b0}};
    end else if (valid_i) begin
      sample_o <= sample_nxt;
    end
  end

  // Gain follows the selected word every cycle, not only with valid samples.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gain_o <= {GAIN_W{1'b0}};
    end else begin
      gain_o <= gain_nxt;
    end
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gain_cdb_o <= {CDB_W{1'b0}};
    end else begin
      gain_cdb_o <= gain_cdb_nxt;
    end
  end

endmodule

//--- shared/agot_defs.vh
// Constants for the converter 15/16 gain and offset trim register bank.
// Assumes inclusion by the bank's design file only.
`ifndef AGOT_DEFS_VH
`define AGOT_DEFS_VH

`define AGOT_ADDR_W           8
`define AGOT_DATA_W           16
`define AGOT_OFF_C15_ODD      8'h35
`define AGOT_OFF_C15_EVEN     8'h36
`define AGOT_OFF_C16_ODD      8'h37
`define AGOT_OFF_C16_EVEN     8'h38
`define AGOT_GAIN_MSB         15
`define AGOT_GAIN_LSB         11
`define AGOT_GAIN_W           5
`define AGOT_OFFS_MSB         9
`define AGOT_OFFS_LSB         0
`define AGOT_OFFS_W           10
`define AGOT_SPARE_BIT        10
`define AGOT_REG_RST          16'h0000
`define AGOT_RD_IDLE          16'h0000
`define AGOT_SMP_W            14
`define AGOT_GAIN_STEP_CDB    5'h14

`endif

//--- verif/agot_regs_checker.sv
// Port-level assertions for the converter 15/16 trim register bank.
// Assumes a bind onto agot_regs and the single clock domain of clk_i.
`timescale 1ns/1ps
module agot_regs_checker (
  input wire        clk_i, nrst_i, wr_i, rd_i, c15_valid_i, c15_valid_o,
  input wire        global_gain_correction_enable_i, global_offset_correction_enable_i,
  input wire [7:0]  addr_i,
  input wire [15:0] wdata_i, rdata_o,
  input wire [13:0] c15_sample_i, c15_sample_o,
  input wire [4:0]  c15_gain_o,
  input wire [9:0]  c15_gain_cdb_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire mapped = addr_i >= 8'h35 && addr_i <= 8'h38;
  a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000) else $error("read data not idle");
  a_gain_gated: assert property (!global_gain_correction_enable_i |=> c15_gain_o == 5'h00) else $error("gain leak");
  a_gain_scale: assert property (c15_gain_cdb_o == c15_gain_o * 10'd20) else $error("gain scale");
  a_valid_delay: assert property (c15_valid_o == $past(c15_valid_i)) else $error("valid delay");
  a_offset_bypass: assert property (c15_valid_i && !global_offset_correction_enable_i
    |=> c15_sample_o == $past(c15_sample_i)) else $error("offset applied while off");
  a_sample_hold: assert property (!c15_valid_i |=> $stable(c15_sample_o)) else $error("sample moved");
  a_write_readback: assert property (wr_i && mapped ##1 rd_i && $stable(addr_i)
    |=> rdata_o == $past(wdata_i, 2)) else $error("readback");
  a_unmapped_zero: assert property (rd_i && !mapped |=> rdata_o == 16'h0000) else $error("unmapped read");
endmodule
bind agot_regs agot_regs_checker u_agot_regs_checker (.*);

//--- verif/tb_agot_regs.sv
// Self-checking random bench for the converter 15/16 trim register bank.
// Assumes the one-cycle strobe bus and 14-bit samples of agot_regs.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin error_cnt++; $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_agot_regs;
  reg         clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, ge = 0, oe = 0, v = 0, od = 0;
  reg  [7:0]  addr_i = 0;
  reg  [15:0] wdata_i = 0, d, rv [0:3];
  reg  [13:0] s15 = 0, s16 = 0;
  wire [15:0] rdata_o;
  wire        v15, v16;
  wire [13:0] o15, o16;
  wire [4:0]  g15, g16;
  wire [9:0]  c15, c16;
  integer     error_cnt = 0, n_checks = 0, seed = 32'h0ed60bf9, cyc = 0, i;
  always #4 clk_i = ~clk_i;
  agot_regs u_agot_regs (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .global_gain_correction_enable_i(ge), .global_offset_correction_enable_i(oe),
    .c15_valid_i(v), .c15_odd_i(od), .c15_sample_i(s15), .c16_valid_i(v), .c16_odd_i(od), .c16_sample_i(s16),
    .c15_valid_o(v15), .c15_sample_o(o15), .c15_gain_o(g15), .c15_gain_cdb_o(c15),
    .c16_valid_o(v16), .c16_sample_o(o16), .c16_gain_o(g16), .c16_gain_cdb_o(c16));
  ////////////////////////////////////////////////////////////////////////////////
  // Saturation mirrors the chosen clamp; a wrap instead would show as a mismatch.
  function [13:0] sat(input [13:0] s, input [9:0] o);
    integer r;
    begin
      r = $signed(s) - $signed(o);
      sat = r > 8191 ? 14'h1FFF : (r < -8192 ? 14'h2000 : r[13:0]);
    end
  endfunction
  task wr(input [7:0] a, input [15:0] x);
    begin
      @(posedge clk_i); wr_i <= 1'b1; rd_i <= 1'b0; addr_i <= a; wdata_i <= x;
    end
  endtask
  task rd(input [7:0] a, input [15:0] e);
    begin
      @(posedge clk_i); rd_i <= 1'b1; wr_i <= 1'b0; addr_i <= a;
      @(posedge clk_i); rd_i <= 1'b0; #1;
      `CHK("rdata", e, rdata_o)
    end
  endtask
  task smp(input p, input [13:0] a, input [13:0] b);
    begin
      @(posedge clk_i); v <= 1'b1; od <= p; s15 <= a; s16 <= b; wr_i <= 1'b0; rd_i <= 1'b0;
      @(posedge clk_i); v <= 1'b0; #1;
      `CHK("valid", 1'b1, v15 & v16)
      `CHK("s15", oe ? sat(a, rv[!p][9:0]) : a, o15)
      `CHK("s16", oe ? sat(b, rv[2 + !p][9:0]) : b, o16)
      `CHK("g15", ge ? rv[!p][15:11] : 5'h00, g15)
      `CHK("cdb16", ge ? rv[2 + !p][15:11] * 10'd20 : 10'h000, c16)
      `CHK("g16", ge ? rv[2 + !p][15:11] : 5'h00, g16)
      `CHK("cdb15", ge ? rv[!p][15:11] * 10'd20 : 10'h000, c15)
    end
  endtask
  task report_and_stop;
    begin
      if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin error_cnt++; report_and_stop; end
  end
  initial begin
    for (i = 0; i < 4; i++) rv[i] = 16'h0000;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (i = 0; i < 6; i++) rd(8'h34 + i, 16'h0000);
    // Addresses 34h and 39h sit just outside the bank, so writes there must vanish.
    repeat (60) begin
      i = $unsigned($random(seed)) % 6;
      d = 16'($random(seed));
      wr(8'h34 + i, d);
      if (i > 0 && i < 5) rv[i - 1] = d;
      rd(8'h34 + i, (i > 0 && i < 5) ? rv[i - 1] : 16'h0000);
      ge <= d[3]; oe <= d[4];
      smp(d[5], 14'($random(seed)), 14'($random(seed)));
    end
    ge <= 1'b1; oe <= 1'b1;
    wr(8'h35, 16'hFA00); rv[0] = 16'hFA00;
    wr(8'h36, 16'h01FF); rv[1] = 16'h01FF;
    wr(8'h37, 16'h0001); rv[2] = 16'h0001;
    wr(8'h38, 16'h03FF); rv[3] = 16'h03FF;
    smp(1'b1, 14'h1FFF, 14'h2000);
    smp(1'b0, 14'h2000, 14'h0005);
    report_and_stop;
  end
endmodule
